// ---- logic/ctx_pkg.sv ----
// package of constants and types for the cell / nibble transmit port
// ==========================================================
// Functional notes
// RULE1 - in cell mode the port is bus master, single or addressed multi PHY
// RULE2 - all cell transmit outputs change on the rising edge of the link clock
// RULE3 - in MII mode the PHY supplies 25 MHz or 2.5 MHz transmit clock
// RULE4 - multi PHY select: address with enable high one clock, then low next clock
// RULE5 - single PHY: enable low tells the PHY data is ready to send
// RULE6 - start flag high exactly in the clock of the first cell byte
// RULE7 - MII mode drives 4-bit nibbles synchronous to the PHY transmit clock
// RULE8 - MII valid rises with first preamble nibble, held until last nibble
// RULE9 - MII nibble on data bits 3:0, MII valid on data bit 4
// RULE10 - multi PHY drives a 5-bit address bus to poll and select PHYs
// RULE11 - polled PHY answers space available one clock after its address
// RULE12 - a cell starts only after its PHY reported space for a full cell
package ctx_pkg;
  localparam int unsigned CELL_BYTES = 53;
  localparam logic [5:0] CELL_LAST = 6'h34;
  localparam logic [4:0] ADDR_IDLE = 5'h1f;
  localparam logic [1:0] SYNC_INIT = 2'h0;
  localparam logic [5:0] CNT_INIT = 6'h00;
  localparam logic [4:0] ADDR_INIT = 5'h00;
  localparam logic [7:0] BYTE_INIT = 8'h00;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_WIDTH = 10;

  typedef enum logic [2:0] {
    CTX_IDLE = 3'b000,
    CTX_POLL = 3'b001,
    CTX_CHECK = 3'b010,
    CTX_SELECT = 3'b011,
    CTX_CELL = 3'b100,
    CTX_FRAME = 3'b101
  } ctx_state_type;
endpackage : ctx_pkg

// ---- logic/ctx_fifo.sv ----
// dual clock FIFO with gray-coded pointers
module ctx_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input wire logic wr_clk_i,
  input wire logic wr_rst_n_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_clk_i,
  input wire logic rd_rst_n_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_bin;
  logic [AW:0] wr_gray;
  logic [AW:0] rd_bin;
  logic [AW:0] rd_gray;
  logic [AW:0] rg_s1;
  logic [AW:0] rg_s2;
  logic [AW:0] wg_s1;
  logic [AW:0] wg_s2;
  logic [AW:0] next_wr_bin;
  logic [AW:0] next_rd_bin;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wr_ready_o = (wr_gray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
  assign rd_valid_o = (rd_gray != wg_s2);
  assign next_wr_bin = wr_bin + {{AW{1'b0}}, 1'b1};
  assign next_rd_bin = rd_bin + {{AW{1'b0}}, 1'b1};
  assign rd_data_o = mem[rd_bin[AW-1:0]];

  always_ff @(posedge wr_clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      mem[wr_bin[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge wr_clk_i or negedge wr_rst_n_i) begin
    if (!wr_rst_n_i) begin
      wr_bin <= '0;
      wr_gray <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      rg_s1 <= rd_gray;
      rg_s2 <= rg_s1;
      if (wr_valid_i && wr_ready_o) begin
        wr_bin <= next_wr_bin;
        wr_gray <= to_gray(next_wr_bin);
      end
    end
  end

  always_ff @(posedge rd_clk_i or negedge rd_rst_n_i) begin
    if (!rd_rst_n_i) begin
      rd_bin <= '0;
      rd_gray <= '0;
      wg_s1 <= '0;
      wg_s2 <= '0;
    end else begin
      wg_s1 <= wr_gray;
      wg_s2 <= wg_s1;
      if (rd_valid_o && rd_ready_i) begin
        rd_bin <= next_rd_bin;
        rd_gray <= to_gray(next_rd_bin);
      end
    end
  end
endmodule // ctx_fifo

// ---- logic/ctx_tx_port.sv ----
// transmit half of the shared cell bus / MII port
module ctx_tx_port (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic mii_mode_i,
  input wire logic multi_phy_mode_i,
  input wire logic [4:0] phy_target_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [7:0] in_data_i,
  input wire logic in_first_i,
  input wire logic in_last_i,
  input wire logic cell_tx_clock_in,
  input wire logic cell_tx_space_available,
  output logic cell_tx_enable_low,
  output logic cell_tx_start_flag,
  output logic [7:0] cell_tx_byte_bus,
  output logic [4:0] cell_tx_phy_select_bus,
  output logic cell_tx_oe_o
);
  // ==========================================================
  // reset and mode crossing into the link domain
  logic lrst_s1;
  logic lrst_n;
  logic [2:0] mii_sync;
  logic [2:0] multi_phy_mode_sync;
  logic mii_mode;
  logic multi_phy_mode_mode;
  logic [4:0] target_s1;
  logic [4:0] target_s2;
  logic [4:0] target_s3;
  logic [4:0] target;

  always_ff @(posedge cell_tx_clock_in or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lrst_s1 <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      lrst_n <= lrst_s1;
    end
  end

  // a mode level is taken only once the second and third stages agree
  always_ff @(posedge cell_tx_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      mii_sync <= 3'h0;
      multi_phy_mode_sync <= 3'h0;
      mii_mode <= 1'b0;
      multi_phy_mode_mode <= 1'b0;
      target_s1 <= ctx_pkg::ADDR_INIT;
      target_s2 <= ctx_pkg::ADDR_INIT;
      target_s3 <= ctx_pkg::ADDR_INIT;
      target <= ctx_pkg::ADDR_INIT;
    end else begin
      mii_sync <= {mii_sync[1:0], mii_mode_i};
      multi_phy_mode_sync <= {multi_phy_mode_sync[1:0], multi_phy_mode_i};
      target_s1 <= phy_target_i;
      target_s2 <= target_s1;
      target_s3 <= target_s2;
      // a multi-bit address is only taken once it has settled
      if (target_s2 == target_s3) begin
        target <= target_s2;
      end
      if (mii_sync[2] == mii_sync[1]) begin
        mii_mode <= mii_sync[1];
      end
      if (multi_phy_mode_sync[2] == multi_phy_mode_sync[1]) begin
        multi_phy_mode_mode <= multi_phy_mode_sync[1];
      end
    end
  end

  // ==========================================================
  // data FIFO, core clock in, link clock out
  logic f_valid;
  logic f_ready;
  logic [9:0] f_data;

  ctx_fifo #(
    .WIDTH(ctx_pkg::FIFO_WIDTH),
    .DEPTH(ctx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_i(core_clk_i),
    .wr_rst_n_i(rst_n_i),
    .wr_valid_i(in_valid_i),
    .wr_ready_o(in_ready_o),
    .wr_data_i({in_first_i, in_last_i, in_data_i}),
    .rd_clk_i(cell_tx_clock_in),
    .rd_rst_n_i(lrst_n),
    .rd_valid_o(f_valid),
    .rd_ready_i(f_ready),
    .rd_data_o(f_data)
  );

  // ==========================================================
  // link state machine
  ctx_pkg::ctx_state_type state;
  ctx_pkg::ctx_state_type next_state;
  logic [5:0] cnt;
  logic space_s1;
  logic space_s2;
  logic space_s3;
  logic space_ok;

  // space flag is asynchronous to this domain only in theory; synchronised anyway
  always_ff @(posedge cell_tx_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      space_s1 <= 1'b0;
      space_s2 <= 1'b0;
      space_s3 <= 1'b0;
    end else begin
      space_s1 <= cell_tx_space_available;
      space_s2 <= space_s1;
      space_s3 <= space_s2;
    end
  end
  assign space_ok = space_s2 & space_s3;

  always_comb begin
    next_state = state;
    f_ready = 1'b0;
    unique case (state)
      ctx_pkg::CTX_IDLE: begin
        if (f_valid && mii_mode) begin
          next_state = ctx_pkg::CTX_FRAME;
        end else if (f_valid && !f_data[9]) begin
          // drop stray bytes so a cell always starts aligned
          f_ready = 1'b1;
        end else if (f_valid) begin
          next_state = ctx_pkg::CTX_POLL;
        end
      end
      ctx_pkg::CTX_POLL: next_state = ctx_pkg::CTX_CHECK;
      ctx_pkg::CTX_CHECK: begin
        // RULE12 wait for space
        if (space_ok) begin
          next_state = multi_phy_mode_mode ? ctx_pkg::CTX_SELECT : ctx_pkg::CTX_CELL;
        end else begin
          next_state = ctx_pkg::CTX_POLL;
        end
      end
      ctx_pkg::CTX_SELECT: next_state = ctx_pkg::CTX_CELL;
      ctx_pkg::CTX_CELL: begin
        f_ready = 1'b1;
        if (!f_valid || cnt == ctx_pkg::CELL_LAST) begin
          next_state = ctx_pkg::CTX_IDLE;
        end
      end
      ctx_pkg::CTX_FRAME: begin
        f_ready = 1'b1;
        if (!f_valid || f_data[8]) begin
          next_state = ctx_pkg::CTX_IDLE;
        end
      end
      default: next_state = ctx_pkg::CTX_IDLE;
    endcase
  end

  always_ff @(posedge cell_tx_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      state <= ctx_pkg::CTX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge cell_tx_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      cnt <= ctx_pkg::CNT_INIT;
    end else if (state == ctx_pkg::CTX_CELL && f_valid) begin
      cnt <= cnt + 6'h01;
    end else if (state != ctx_pkg::CTX_CELL) begin
      cnt <= ctx_pkg::CNT_INIT;
    end
  end

  // ==========================================================
  // pin registers, all on the rising link clock edge
  // RULE2 registered outputs
  always_ff @(posedge cell_tx_clock_in or negedge lrst_n) begin
    if (!lrst_n) begin
      cell_tx_enable_low <= 1'b1;
      cell_tx_start_flag <= 1'b0;
      cell_tx_byte_bus <= ctx_pkg::BYTE_INIT;
      cell_tx_phy_select_bus <= ctx_pkg::ADDR_IDLE;
    end else begin
      cell_tx_enable_low <= 1'b1;
      cell_tx_start_flag <= 1'b0;
      cell_tx_byte_bus <= ctx_pkg::BYTE_INIT;
      cell_tx_phy_select_bus <= ctx_pkg::ADDR_IDLE;
      unique case (next_state)
        ctx_pkg::CTX_POLL,
        ctx_pkg::CTX_CHECK: begin
          // RULE10 poll address, held while the answer settles
          cell_tx_phy_select_bus <= multi_phy_mode_mode ? target : ctx_pkg::ADDR_IDLE;
        end
        ctx_pkg::CTX_SELECT: begin
          // RULE4 select step one
          cell_tx_phy_select_bus <= target;
        end
        ctx_pkg::CTX_CELL: begin
          // RULE1 RULE5 enable low while sending
          cell_tx_enable_low <= 1'b0;
        end
        default: begin
        end
      endcase
      // keyed on the current state so the last byte is sent as the state leaves
      if (state == ctx_pkg::CTX_CELL && f_valid) begin
        cell_tx_enable_low <= 1'b0;
        cell_tx_byte_bus <= f_data[7:0];
        // RULE6 start flag on first byte
        cell_tx_start_flag <= (cnt == ctx_pkg::CNT_INIT);
      end
      if (state == ctx_pkg::CTX_FRAME && f_valid) begin
        // RULE7 RULE8 RULE9 nibble on bits 3:0, valid on bit 4
        cell_tx_byte_bus <= {3'h0, 1'b1, f_data[3:0]};
      end
    end
  end

  assign cell_tx_oe_o = lrst_n;

  // ==========================================================
  // checks
  // RULE4 enable high then low
  a_select_two_step: assert property (@(posedge cell_tx_clock_in) disable iff (!lrst_n)
    (state == ctx_pkg::CTX_SELECT) |-> cell_tx_enable_low ##1 !cell_tx_enable_low)
    else $error("select step did not drive enable high then low");
  a_select_address: assert property (@(posedge cell_tx_clock_in) disable iff (!lrst_n) // RULE4
    (state == ctx_pkg::CTX_SELECT) |-> cell_tx_phy_select_bus == target)
    else $error("select step without the target address");
  a_frame_no_enable: assert property (@(posedge cell_tx_clock_in) disable iff (!lrst_n) // RULE9
    (state == ctx_pkg::CTX_FRAME) |-> cell_tx_enable_low && !cell_tx_start_flag)
    else $error("cell pins active during a nibble frame");
  // RULE12 space before cell
  a_space_before_cell: assert property (@(posedge cell_tx_clock_in) disable iff (!lrst_n)
    (state == ctx_pkg::CTX_CHECK && !space_ok) |=> state == ctx_pkg::CTX_POLL)
    else $error("cell began without space available");
  // RULE6 start flag only in a cell
  a_start_in_cell: assert property (@(posedge cell_tx_clock_in) disable iff (!lrst_n)
    cell_tx_start_flag |-> !cell_tx_enable_low && !mii_mode)
    else $error("start flag outside cell transfer");
  // RULE8 valid follows frame state
  a_frame_valid: assert property (@(posedge cell_tx_clock_in) disable iff (!lrst_n)
    (state == ctx_pkg::CTX_FRAME && $past(state) == ctx_pkg::CTX_FRAME)
      |-> cell_tx_byte_bus[4])
    else $error("frame valid dropped mid frame");
endmodule // ctx_tx_port

// ---- testbench/ctx_phy_model.sv ----
// far side PHY model: answers polls and records what the port sends
module ctx_phy_model (
  input wire logic clk_i,
  input wire logic mii_i,
  input wire logic multi_i,
  input wire logic ready_i,
  input wire logic [4:0] my_addr_i,
  input wire logic enable_low_i,
  input wire logic start_i,
  input wire logic [7:0] bus_i,
  input wire logic [4:0] addr_i,
  output logic space_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [3:0] nib[$];
  int cells = 0;
  int bad = 0;
  int rises = 0;
  int left = 0;
  logic en_q = 1'b1;
  logic v_q = 1'b0;
  logic [4:0] a_q = 5'h1f;
  initial space_o = 1'b0;
  // ========
  // everything is sampled on the rising link edge
  always @(posedge clk_i) begin
    space_o <= ready_i && (!multi_i || addr_i == my_addr_i);
    en_q <= enable_low_i;
    a_q <= addr_i;
    v_q <= bus_i[4];
    if (!mii_i && multi_i && en_q && !enable_low_i && a_q !== my_addr_i) bad++;
    if (!mii_i && start_i) begin
      cells++;
      left = 53;
      if (enable_low_i) bad++;
    end
    if (!mii_i && left > 0 && !enable_low_i) begin
      got.push_back(bus_i);
      left--;
    end
    if (mii_i && bus_i[4]) nib.push_back(bus_i[3:0]);
    if (mii_i && bus_i[4] && !v_q) rises++;
  end
endmodule // ctx_phy_model

// ---- testbench/cell_and_nibble_tx_port_test.sv ----
// self-checking bench for the cell / nibble transmit port
module cell_and_nibble_tx_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic link_clk = 1'b0;
  logic mii = 1'b0;
  logic multi = 1'b0;
  logic ready = 1'b1;
  logic [4:0] target = 5'h00;
  logic in_valid_i = 1'b0;
  logic [7:0] in_data_i = 8'h00;
  logic in_first_i = 1'b0;
  logic in_last_i = 1'b0;
  logic in_ready_o, space, enable_low, start, oe;
  logic [7:0] bus;
  logic [4:0] sel;
  logic [7:0] exp_c[$];
  logic [3:0] exp_m[$];
  int seed = 92;
  int miscompares = 0;
  int comparisons = 0;
  logic refused = 1'b0;

  always #2 core_clk_i = ~core_clk_i;
  always #62.5 link_clk = ~link_clk;

  ctx_tx_port dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mii_mode_i(mii),
    .multi_phy_mode_i(multi), .phy_target_i(target), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .in_data_i(in_data_i), .in_first_i(in_first_i),
    .in_last_i(in_last_i), .cell_tx_clock_in(link_clk),
    .cell_tx_space_available(space), .cell_tx_enable_low(enable_low),
    .cell_tx_start_flag(start), .cell_tx_byte_bus(bus),
    .cell_tx_phy_select_bus(sel), .cell_tx_oe_o(oe)
  );
  ctx_phy_model phy (
    .clk_i(link_clk), .mii_i(mii), .multi_i(multi), .ready_i(ready),
    .my_addr_i(target), .enable_low_i(enable_low), .start_i(start),
    .bus_i(bus), .addr_i(sel), .space_o(space)
  );

  // ========
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // holds the request until ready was seen before an edge
  task automatic push(input logic [7:0] d, input logic f, l);
    int n;
    n = 0;
    in_valid_i = 1'b1;
    in_data_i = d;
    in_first_i = f;
    in_last_i = l;
    while (in_ready_o !== 1'b1 && n < 9000) begin
      refused = 1'b1;
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n >= 9000) begin
      miscompares++;
      finish_test();
    end
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic send(input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = (i == 1) ? 8'hff : 8'($random(seed));
      if (mii) exp_m.push_back(b[3:0]);
      else exp_c.push_back(b);
      push(b, i == 0, i == n - 1);
    end
    in_valid_i = 1'b0;
  endtask

  task automatic wait_n(input int n);
    int k;
    k = 0;
    while (phy.got.size() + phy.nib.size() < n && k < 20000) begin
      @(posedge core_clk_i);
      k++;
    end
    if (k >= 20000) begin
      miscompares++;
      finish_test();
    end
    #1;
  endtask

  // ========
  initial begin
    repeat (4) @(posedge link_clk);
    check("enable in reset", enable_low, 1'b1);
    check("flag in reset", start, 1'b0);
    check("addr in reset", sel, 5'h1f);
    @(posedge core_clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (3) @(posedge link_clk);
    #1;
    check("pins driven", oe, 1'b1);
    @(posedge core_clk_i);
    #1;
    send(53);
    wait_n(53);
    check("single cells", phy.cells, 1);
    multi = 1'b1;
    ready = 1'b0;
    target = 5'(($random(seed) & 32'h7fff_ffff) % 31);
    // far side stalls while the buffer fills up
    fork
      send(53);
      begin
        repeat (3000) @(posedge core_clk_i);
        check("cells before space", phy.cells, 1);
        #1;
        ready = 1'b1;
      end
    join
    wait_n(106);
    check("buffer refused", refused, 1'b1);
    check("select faults", phy.bad, 0);
    check("cell bytes", phy.got.size(), 106);
    foreach (exp_c[i]) check("cell byte", phy.got[i], exp_c[i]);
    multi = 1'b0;
    mii = 1'b1;
    repeat (16) @(posedge link_clk);
    @(posedge core_clk_i);
    #1;
    send(14);
    wait_n(120);
    repeat (8) @(posedge link_clk);
    check("valid rises", phy.rises, 1);
    check("nibbles", phy.nib.size(), 14);
    foreach (exp_m[i]) check("nibble", phy.nib[i], exp_m[i]);
    check("buffer drained", in_ready_o, 1'b1);
    finish_test();
  end
endmodule // cell_and_nibble_tx_port_test
